// [tarc_top.sv]
// analog front end setting reconfiguration controller
//
// Contract
// [RL1] broadcast mode writes all channels, no select
// [RL2] broadcast write ports fixed 3/5/2/4 bits
// [RL3] read-back ports one slice per channel
// [RL4] slices packed from lsb upward
// [RL5] direction 2'b10 touches transmit side only
// [RL6] user presents settings, checks busy low first
// [RL7] write strobe is one-cycle pulse
// [RL8] busy high while writing, low when done
// [RL9] read request is one-cycle pulse, busy low
// [RL10] busy during read, then data_valid asserted
// [RL11] never write and read together
// [RL12] per-channel mode has per-channel write slices
// [RL13] per-channel write updates every channel
// [RL14] direction picks both, transmit or receive
// [RL15] per-channel method is slowest
// [RL16] read-back stays per-channel in all modes
// [RL17] ignore strobes while busy, hold read-back
`timescale 1ns/1ps
`include "tarc_cfg.svh"
module tarc_top
   import tarc_pkg::*;
#(
   parameter bit PER_CHANNEL = 1'b0
)(
   input  wire logic                                mclk,
   input  wire logic                                sys_rst,
   input  wire logic                                write_all,
   input  wire logic                                read_req,
   input  wire logic [1:0]                          dir_sel,
   // [RL2] fixed-width broadcast settings
   input  wire logic [`TARC_SWING_W-1:0]            bc_output_swing,
   input  wire logic [`TARC_PREEMP_W-1:0]           bc_preemp,
   input  wire logic [`TARC_DCGAIN_W-1:0]           bc_dcgain,
   input  wire logic [`TARC_EQ_W-1:0]               bc_eq,
   input  wire logic [`TARC_NCH*`TARC_SWING_W-1:0]  pc_output_swing,
   input  wire logic [`TARC_NCH*`TARC_PREEMP_W-1:0] pc_preemp,
   input  wire logic [`TARC_NCH*`TARC_DCGAIN_W-1:0] pc_dcgain,
   input  wire logic [`TARC_NCH*`TARC_EQ_W-1:0]     pc_eq,
   output logic                                     busy_q,
   output logic                                     data_valid_q,
   // [RL3] per-channel read-back slices
   output logic [`TARC_NCH*`TARC_SWING_W-1:0]       output_swing_out_q,
   output logic [`TARC_NCH*`TARC_PREEMP_W-1:0]      preemp_out_q,
   output logic [`TARC_NCH*`TARC_DCGAIN_W-1:0]      dcgain_out_q,
   output logic [`TARC_NCH*`TARC_EQ_W-1:0]          eq_out_q,
   output logic [`TARC_NCH*`TARC_SWING_W-1:0]       afe_swing_q,
   output logic [`TARC_NCH*`TARC_PREEMP_W-1:0]      afe_preemp_q,
   output logic [`TARC_NCH*`TARC_DCGAIN_W-1:0]      afe_dcgain_q,
   output logic [`TARC_NCH*`TARC_EQ_W-1:0]          afe_eq_q
);
   localparam int NCH = `TARC_NCH;
   localparam int SW  = `TARC_SWING_W;
   localparam int PW  = `TARC_PREEMP_W;
   localparam int GW  = `TARC_DCGAIN_W;
   localparam int EW  = `TARC_EQ_W;

   tarc_state_t state_q;
   logic [3:0]  cnt_q;
   logic [1:0]  dir_q;
   logic        done;
   logic        inc_tx;
   logic        inc_rx;
   logic        commit;

   ////////////////////////////////////////////////////////////////////////
   // transaction sequencing
   assign done   = (cnt_q == `TARC_XFER_CYC - 4'h1);
   assign commit = (state_q == TARC_WRITE) && done;
   // [RL14] direction decode
   assign inc_tx = (dir_q != `TARC_DIR_RX);
   // [RL5] transmit-only excludes receive
   assign inc_rx = (dir_q != `TARC_DIR_TX);

   // state and busy; [RL17] strobes ignored unless idle
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         state_q <= TARC_IDLE;
         busy_q  <= 1'b0;
         dir_q   <= `TARC_DIR_BOTH;
      end else begin
         unique case (state_q)
            TARC_IDLE: begin
               // [RL8] busy raised on write
               if (write_all) begin
                  state_q <= TARC_WRITE;
                  busy_q  <= 1'b1;
                  dir_q   <= dir_sel;
               end else if (read_req) begin
                  state_q <= TARC_READ;
                  busy_q  <= 1'b1;
                  dir_q   <= dir_sel;
               end
            end
            TARC_WRITE, TARC_READ: begin
               if (done) begin
                  state_q <= TARC_IDLE;
                  busy_q  <= 1'b0;
               end
            end
         endcase
      end
   end

   // cycle counter for transfer length
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) cnt_q <= 4'h0;
      else if (state_q == TARC_IDLE) cnt_q <= 4'h0;
      else cnt_q <= cnt_q + 4'h1;
   end

   // [RL10] read-valid flag after read finishes
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) data_valid_q <= 1'b0;
      else if (state_q == TARC_READ && done) data_valid_q <= 1'b1;
      else if (state_q == TARC_IDLE && (write_all || read_req))
         data_valid_q <= 1'b0;
   end

   ////////////////////////////////////////////////////////////////////////
   // per-channel stores and read-back
   genvar g;
   generate
      for (g = 0; g < NCH; g++) begin : g_ch
         logic [SW-1:0] sw_in, sw_v;
         logic [PW-1:0] pe_in, pe_v;
         logic [GW-1:0] dg_in, dg_v;
         logic [EW-1:0] eq_in, eq_v;
         logic [SW-1:0] rb_sw_q;
         logic [PW-1:0] rb_pe_q;
         logic [GW-1:0] rb_dg_q;
         logic [EW-1:0] rb_eq_q;
         // [RL1] broadcast feeds every channel
         // [RL12] per-channel slices select
         assign sw_in = PER_CHANNEL ? pc_output_swing[g*SW +: SW]
                                    : bc_output_swing;
         assign pe_in = PER_CHANNEL ? pc_preemp[g*PW +: PW] : bc_preemp;
         assign dg_in = PER_CHANNEL ? pc_dcgain[g*GW +: GW] : bc_dcgain;
         assign eq_in = PER_CHANNEL ? pc_eq[g*EW +: EW] : bc_eq;

         // [RL13] every channel written together
         tarc_chan u_chan (
            .mclk      (mclk),
            .sys_rst   (sys_rst),
            .wr_tx     (commit && inc_tx),
            .wr_rx     (commit && inc_rx),
            .swing_in  (sw_in),
            .preemp_in (pe_in),
            .dcgain_in (dg_in),
            .eq_in     (eq_in),
            .swing_q   (sw_v),
            .preemp_q  (pe_v),
            .dcgain_q  (dg_v),
            .eq_q      (eq_v)
         );
         assign afe_swing_q[g*SW +: SW]  = sw_v;
         assign afe_preemp_q[g*PW +: PW] = pe_v;
         assign afe_dcgain_q[g*GW +: GW] = dg_v;
         assign afe_eq_q[g*EW +: EW]     = eq_v;

         // read-back capture, selected side only
         always_ff @(posedge mclk or posedge sys_rst) begin
            if (sys_rst) begin
               rb_sw_q <= `TARC_SWING_RST;
               rb_pe_q <= `TARC_PREEMP_RST;
               rb_dg_q <= `TARC_DCGAIN_RST;
               rb_eq_q <= `TARC_EQ_RST;
            end else if (state_q == TARC_READ && done) begin
               // [RL16] per-channel read-back in all modes
               if (inc_tx) begin
                  rb_sw_q <= sw_v;
                  rb_pe_q <= pe_v;
               end
               if (inc_rx) begin
                  rb_dg_q <= dg_v;
                  rb_eq_q <= eq_v;
               end
            end
         end
         // [RL4] lsb-first read-back packing
         assign output_swing_out_q[g*SW +: SW] = rb_sw_q;
         assign preemp_out_q[g*PW +: PW]       = rb_pe_q;
         assign dcgain_out_q[g*GW +: GW]       = rb_dg_q;
         assign eq_out_q[g*EW +: EW]           = rb_eq_q;
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////
   // checks
   // [RL8] busy frames write
   a_busy_on_write: assert property ( // [RL8]
      @(posedge mclk) disable iff (sys_rst)
      (!busy_q && write_all) |=> busy_q [*8] ##1 !busy_q)
      else $error("busy did not frame write");
   // [RL10] valid ends read
   a_valid_after_read: assert property ( // [RL10]
      @(posedge mclk) disable iff (sys_rst)
      (!busy_q && !write_all && read_req) |=> ##8 (!busy_q && data_valid_q))
      else $error("read did not end with valid");
   // [RL17] read-back held
   a_readback_hold: assert property ( // [RL17]
      @(posedge mclk) disable iff (sys_rst)
      (state_q != TARC_READ) |=> $stable(output_swing_out_q))
      else $error("read-back changed outside read");
   // [RL5] transmit-only write
   a_tx_only_rx: assert property ( // [RL5]
      @(posedge mclk) disable iff (sys_rst)
      (commit && dir_q == `TARC_DIR_TX) |=> $stable(afe_eq_q))
      else $error("rx touched in tx-only write");
   // [RL14] receive-only write
   a_rx_only_tx: assert property ( // [RL14]
      @(posedge mclk) disable iff (sys_rst)
      (commit && dir_q == `TARC_DIR_RX) |=> $stable(afe_swing_q))
      else $error("tx touched in rx-only write");
   // [RL1] broadcast reaches channels
   a_bcast_all: assert property ( // [RL1]
      @(posedge mclk) disable iff (sys_rst)
      (commit && inc_tx && !PER_CHANNEL && $stable(bc_output_swing))
      |=> afe_swing_q[SW-1:0] == afe_swing_q[2*SW-1:SW])
      else $error("broadcast not equal on channels");
   // [RL13] all slices written
   a_pc_slice: assert property ( // [RL13]
      @(posedge mclk) disable iff (sys_rst)
      (commit && inc_tx && PER_CHANNEL)
      |=> afe_swing_q == $past(pc_output_swing))
      else $error("per-channel write mismatch");
   // [RL17] busy strobes ignored
   a_ignore_busy: assert property ( // [RL17]
      @(posedge mclk) disable iff (sys_rst)
      (busy_q && cnt_q != 4'h7) |=> busy_q && $stable(dir_q))
      else $error("strobe during busy acted");
   // [RL4] slice placement
   a_readback_pack: assert property ( // [RL4]
      @(posedge mclk) disable iff (sys_rst)
      (state_q == TARC_READ && done && inc_tx)
      |=> output_swing_out_q[2*SW-1:SW] == afe_swing_q[2*SW-1:SW])
      else $error("read-back slice misplaced");
endmodule : tarc_top

// [tarc_cfg.svh]
// timing counts and encodings for the analog setting controller
`ifndef TARC_CFG_SVH
`define TARC_CFG_SVH
`define TARC_NCH          4
`define TARC_SWING_W      3
`define TARC_PREEMP_W     5
`define TARC_DCGAIN_W     2
`define TARC_EQ_W         4
`define TARC_DIR_BOTH     2'h0
`define TARC_DIR_RX       2'h1
`define TARC_DIR_TX       2'h2
`define TARC_XFER_CYC     4'h8
`define TARC_SWING_RST    3'h0
`define TARC_PREEMP_RST   5'h00
`define TARC_DCGAIN_RST   2'h0
`define TARC_EQ_RST       4'h0
`endif

// [tarc_pkg.sv]
// types for the analog setting controller
`include "tarc_cfg.svh"
package tarc_pkg;
   typedef enum logic [2:0] {
      TARC_IDLE  = 3'b001,
      TARC_WRITE = 3'b010,
      TARC_READ  = 3'b100
   } tarc_state_t;
endpackage : tarc_pkg

// [tarc_chan.sv]
// one channel's analog front end setting store
`timescale 1ns/1ps
`include "tarc_cfg.svh"
module tarc_chan
   import tarc_pkg::*;
(
   input  wire logic                      mclk,
   input  wire logic                      sys_rst,
   input  wire logic                      wr_tx,
   input  wire logic                      wr_rx,
   input  wire logic [`TARC_SWING_W-1:0]  swing_in,
   input  wire logic [`TARC_PREEMP_W-1:0] preemp_in,
   input  wire logic [`TARC_DCGAIN_W-1:0] dcgain_in,
   input  wire logic [`TARC_EQ_W-1:0]     eq_in,
   output logic      [`TARC_SWING_W-1:0]  swing_q,
   output logic      [`TARC_PREEMP_W-1:0] preemp_q,
   output logic      [`TARC_DCGAIN_W-1:0] dcgain_q,
   output logic      [`TARC_EQ_W-1:0]     eq_q
);
   // transmit side settings
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         swing_q  <= `TARC_SWING_RST;
         preemp_q <= `TARC_PREEMP_RST;
      end else if (wr_tx) begin
         swing_q  <= swing_in;
         preemp_q <= preemp_in;
      end
   end
   // receive side settings
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         dcgain_q <= `TARC_DCGAIN_RST;
         eq_q     <= `TARC_EQ_RST;
      end else if (wr_rx) begin
         dcgain_q <= dcgain_in;
         eq_q     <= eq_in;
      end
   end
endmodule : tarc_chan

// [tarc_user.sv]
// fabric-side user logic issuing setting write and read strobes
`timescale 1ns/1ps
module tarc_user (
   input  wire logic       mclk,
   input  wire logic       busy_q,
   output logic            write_all,
   output logic            read_req,
   output logic [1:0]      dir_sel
);
   // idle strobes from time zero
   initial begin
      write_all = 1'b0;
      read_req = 1'b0;
      dir_sel = 2'h0;
   end

   // one transfer; n counts busy cycles seen
   task automatic xfer(input bit wr, input logic [1:0] d, input bit poke,
                       output int n);
      n = 0;
      @(negedge mclk);
      while (busy_q !== 1'b0) @(negedge mclk);
      dir_sel = d;
      write_all = wr;
      read_req = !wr;
      @(negedge mclk);
      write_all = 1'b0;
      read_req = 1'b0;
      // busy is already up at the falling edge after the strobe
      while (busy_q === 1'b1 && n < 20) begin
         n++;
         write_all = poke && (n == 3); // stray strobe while busy
         @(negedge mclk);
      end
      write_all = 1'b0;
   endtask : xfer
endmodule : tarc_user

// [tb.sv]
// self-checking bench for the analog setting controller, both modes
`timescale 1ns/1ps
module tb;
   logic mclk = 1'b0, sys_rst = 1'b1, write_all, read_req;
   logic [1:0] dir_sel;
   logic [2:0] bsw = 3'h0;
   logic [4:0] bpe = 5'h00;
   logic [1:0] bdg = 2'h0;
   logic [3:0] beq = 4'h0;
   logic [11:0] psw = 12'h000, asw[2], osw[2];
   logic [19:0] ppe = 20'h00000, ape[2], ope[2];
   logic [7:0] pdg = 8'h00, adg[2], odg[2];
   logic [15:0] peq = 16'h0000, aeq[2], oeq[2];
   logic busy[2], dv[2];
   logic [55:0] eafe[2] = '{2{56'h0}}, erb[2] = '{2{56'h0}};
   int error_cnt = 0, n_checks = 0, n;

   // clock at 50 ns period
   always #25 mclk = ~mclk;

   // broadcast instance 0, per-channel instance 1
   for (genvar g = 0; g < 2; g++) begin : gi
      tarc_top #(.PER_CHANNEL(g == 1)) i_tarc_top (
         .mclk(mclk), .sys_rst(sys_rst), .write_all(write_all),
         .read_req(read_req), .dir_sel(dir_sel), .bc_output_swing(bsw),
         .bc_preemp(bpe), .bc_dcgain(bdg), .bc_eq(beq),
         .pc_output_swing(psw), .pc_preemp(ppe), .pc_dcgain(pdg),
         .pc_eq(peq), .busy_q(busy[g]), .data_valid_q(dv[g]),
         .output_swing_out_q(osw[g]), .preemp_out_q(ope[g]),
         .dcgain_out_q(odg[g]), .eq_out_q(oeq[g]), .afe_swing_q(asw[g]),
         .afe_preemp_q(ape[g]), .afe_dcgain_q(adg[g]), .afe_eq_q(aeq[g]));
   end
   tarc_user i_tarc_user (.mclk(mclk), .busy_q(busy[0]),
      .write_all(write_all), .read_req(read_req), .dir_sel(dir_sel));

   // merge new settings into old per direction select
   function automatic logic [55:0] upd(input logic [55:0] o, v,
                                       input logic [1:0] d);
      logic [55:0] m;
      m = (d == 2'h1) ? 56'h0000_0000_FF_FFFF :
          (d == 2'h2) ? 56'hFFFF_FFFF_00_0000 : 56'hFFFF_FFFF_FF_FFFF;
      return (o & ~m) | (v & m);
   endfunction : upd

   task automatic chk(input logic [55:0] got, exp, input string what);
      n_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("CHECK FAILED at %0t: %s", $time, what);
      end
   endtask : chk

   // compare live, read-back and valid of both instances
   task automatic chk_state(input logic v);
      for (int i = 0; i < 2; i++) begin
         chk({asw[i], ape[i], adg[i], aeq[i]}, eafe[i], "live");
         chk({osw[i], ope[i], odg[i], oeq[i]}, erb[i], "readback");
         chk(dv[i], v, "data valid");
      end
   endtask : chk_state

   task automatic t_write(input logic [1:0] d, input logic [13:0] b,
                          input logic [55:0] p);
      {bsw, bpe, bdg, beq} = b;
      {psw, ppe, pdg, peq} = p;
      i_tarc_user.xfer(1'b1, d, 1'b0, n);
      chk(n, 56'h8, "write busy length");
      eafe[0] = upd(eafe[0], {{4{bsw}}, {4{bpe}}, {4{bdg}}, {4{beq}}}, d);
      eafe[1] = upd(eafe[1], p, d);
      chk_state(1'b0);
   endtask : t_write

   task automatic t_read(input logic [1:0] d, input bit poke);
      i_tarc_user.xfer(1'b0, d, poke, n);
      chk(n, 56'h8, "read busy length");
      for (int i = 0; i < 2; i++) erb[i] = upd(erb[i], eafe[i], d);
      chk_state(1'b1);
      @(negedge mclk);
      chk(busy[0], 1'b0, "stray strobe taken");
   endtask : t_read

   // change channel 2 swing only, others fed back from read-back
   // slow path: read, then transmit-side write of every channel
   task automatic t_rmw;
      logic [55:0] p;
      t_read(2'h0, 1'b0);
      p = {osw[1], ope[1], odg[1], oeq[1]};
      p[52:50] = 3'h5;
      t_write(2'h2, {bsw, bpe, bdg, beq}, p);
      chk(asw[1], {osw[1][11:9], 3'h5, osw[1][5:0]}, "slice");
   endtask : t_rmw

   task automatic wrap_up;
      $display("checks %0d errors %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask : wrap_up

   // reset, then scenarios
   initial begin
      repeat (6) @(posedge mclk);
      @(negedge mclk) sys_rst = 1'b0;
      chk_state(1'b0);
      t_write(2'h0, 14'h2B5E, 56'h9A3_C5F1E_B4_E1D7);
      t_write(2'h2, 14'h15A1, 56'h25C_3A0E1_4B_1E28);
      t_write(2'h1, 14'h3E7B, 56'hDB6_F0C3A_D2_7C95);
      t_write(2'h3, 14'h0C96, 56'h64A_8E257_69_A36B);
      t_read(2'h2, 1'b0);
      t_read(2'h1, 1'b1);
      t_rmw;
      wrap_up;
   end

   // watchdog well beyond the expected run
   initial begin
      #(50 * 5000);
      error_cnt++;
      wrap_up;
   end
endmodule : tb
